// ===== bei_pkg.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// shared constants and carriers
// ------------------------------------------------------------
package bei_pkg;
  localparam int unsigned AW          = 13;
  localparam int unsigned DW          = 8;
  localparam logic [2:0]  OP_EXEC     = 3'h4;
  localparam logic [2:0]  OP_BRANCH   = 3'h5;
  localparam logic [2:0]  OP_LOAD     = 3'h6;
  localparam logic [2:0]  OP_JUMP     = 3'h7;
  localparam logic [4:0]  D_ADDR_LEFT = 5'h07;
  localparam logic [4:0]  D_ADDR_RGHT = 5'h0f;
  localparam logic [4:0]  D_DATA_LEFT = 5'h0a;
  localparam logic [4:0]  D_DATA_RGHT = 5'h0b;
  localparam logic [3:0]  R_OVERFLOW  = 4'h8;
  localparam logic [12:0] AR_RESET    = 13'h0000;
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [12:0] PC_STEP     = 13'h0001;
  localparam logic [7:0]  IV_IDLE     = 8'h00;

  typedef struct packed {
    logic [2:0] op;
    logic [4:0] sel;
    logic [7:0] imm;
  } bei_instr_s;

  typedef struct packed {
    logic [7:0] data;
    logic       oe;
    logic       is_addr;
    logic       right;
  } bei_iv_s;
endpackage : bei_pkg

// ------------------------------------------------------------
// rotate right and mask low bits, zero length means eight
// ------------------------------------------------------------
module bei_field_extract (
  input  wire logic [7:0] data_in,
  input  wire logic [2:0] rot_in,
  input  wire logic [2:0] len_in,
  output logic      [7:0] field_out
);
  logic [15:0] dbl;
  logic [7:0]  rotated;
  logic [7:0]  mask;

  assign dbl     = {data_in, data_in} >> rot_in;
  assign rotated = dbl[7:0];
  assign mask    = (len_in == 3'h0) ? 8'hff : 8'(8'hff >> (4'h8 - {1'b0, len_in})); // RQ16
  assign field_out = rotated & mask;
endmodule : bei_field_extract

// ===== bei_unit.sv
// Behaviour
// RQ1: register test nonzero loads low eight address bits
// RQ2: register test zero steps program counter
// RQ3: register indirect puts 8-bit sum in address
// RQ4: indirect execute keeps program counter
// RQ5: executed instruction steps program counter normally
// RQ6: jump or branch reached indirectly loads counter
// RQ7: register indirect drops carry, overflow untouched
// RQ8: register immediate load writes working register
// RQ9: address immediate drives bus, saves R7/R17
// RQ10: data immediate drives bus, no register change
// RQ11: bus test rotates, masks selected bank data
// RQ12: bus test nonzero loads low five bits
// RQ13: bus test zero steps program counter
// RQ14: bus indirect puts 5-bit sum in address
// RQ15: bus indirect drops carry, overflow untouched
// RQ16: zero field length selects eight bits
// RQ17: jump loads 13-bit target into both
// RQ18: partial replacement keeps upper address bits
`timescale 1ns/100ps
module bei_unit (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire bei_pkg::bei_instr_s instr_in,
  input  wire logic [7:0]          iv_left_in,
  input  wire logic [7:0]          iv_right_in,
  output logic [12:0]              addr_out,
  output logic [12:0]              pc_out,
  output bei_pkg::bei_iv_s         iv_out,
  output logic [7:0]               overflow_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [12:0]      ar_reg;
  logic [12:0]      pc_reg;
  logic [12:0]      ar_next;
  logic [12:0]      pc_next;
  logic [7:0]       wreg_reg [16];
  bei_pkg::bei_iv_s iv_reg;
  bei_pkg::bei_iv_s iv_next;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic       bus_src;
  logic [7:0] bus_byte;
  logic [7:0] field;
  logic [7:0] src_val;
  logic [7:0] sum8;
  logic [4:0] sum5;
  logic       nonzero;
  logic       wr_en;
  logic       is_exec;
  logic       is_branch;
  logic       is_jump;
  logic       is_load;

  assign is_exec   = (instr_in.op == bei_pkg::OP_EXEC);
  assign is_branch = (instr_in.op == bei_pkg::OP_BRANCH);
  assign is_jump   = (instr_in.op == bei_pkg::OP_JUMP);
  assign is_load   = (instr_in.op == bei_pkg::OP_LOAD);
  assign bus_src  = instr_in.sel[4];
  assign bus_byte = instr_in.sel[3] ? iv_right_in : iv_left_in; // RQ11
  assign src_val  = wreg_reg[instr_in.sel[3:0]];
  assign sum8     = src_val + instr_in.imm; // RQ7
  assign sum5     = field[4:0] + instr_in.imm[4:0]; // RQ15
  assign nonzero  = bus_src ? (field != 8'h00) : (src_val != 8'h00); // RQ11

  bei_field_extract u_extract (
    .data_in   (bus_byte),
    .rot_in    (instr_in.sel[2:0]),
    .len_in    (instr_in.imm[7:5]),
    .field_out (field)
  );

  assign wr_en = is_load && !bus_src && (instr_in.sel != bei_pkg::D_DATA_LEFT)
                 && (instr_in.sel != bei_pkg::D_DATA_RGHT)
                 && (instr_in.sel[3:0] != bei_pkg::R_OVERFLOW);

  // ------------------------------------------------------------
  // address and program counter
  // ------------------------------------------------------------
  always_comb begin
    pc_next = pc_reg + bei_pkg::PC_STEP; // RQ2 RQ5 RQ13
    ar_next = pc_reg + bei_pkg::PC_STEP;
    if (is_branch && nonzero) begin
      if (bus_src) begin
        pc_next = {pc_reg[12:5], instr_in.imm[4:0]}; // RQ12 RQ18
        ar_next = {ar_reg[12:5], instr_in.imm[4:0]};
      end else begin
        pc_next = {pc_reg[12:8], instr_in.imm}; // RQ1 RQ18 RQ6
        ar_next = {ar_reg[12:8], instr_in.imm};
      end
    end else if (is_exec) begin
      pc_next = pc_reg; // RQ4
      if (bus_src) begin
        ar_next = {ar_reg[12:5], sum5}; // RQ14
      end else begin
        ar_next = {ar_reg[12:8], sum8}; // RQ3
      end
    end else if (is_jump) begin
      pc_next = {instr_in.sel, instr_in.imm}; // RQ17 RQ6
      ar_next = {instr_in.sel, instr_in.imm};
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ar_reg <= bei_pkg::AR_RESET;
      pc_reg <= bei_pkg::PC_RESET;
    end else begin
      ar_reg <= ar_next;
      pc_reg <= pc_next;
    end
  end

  // ------------------------------------------------------------
  // working registers
  // ------------------------------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_wreg
    always_ff @(posedge clk_in) begin
      if (wr_en && (instr_in.sel[3:0] == 4'(i))) begin
        wreg_reg[i] <= instr_in.imm; // RQ8 RQ9
      end
    end
  end

  // ------------------------------------------------------------
  // interface vector bus drive
  // ------------------------------------------------------------
  always_comb begin
    iv_next = '{data: bei_pkg::IV_IDLE, oe: 1'b0, is_addr: 1'b0, right: 1'b0};
    if (is_load && ((instr_in.sel == bei_pkg::D_ADDR_LEFT)
                    || (instr_in.sel == bei_pkg::D_ADDR_RGHT))) begin
      iv_next = '{data: instr_in.imm, oe: 1'b1, is_addr: 1'b1, right: instr_in.sel[3]}; // RQ9
    end else if (is_load && ((instr_in.sel == bei_pkg::D_DATA_LEFT)
                             || (instr_in.sel == bei_pkg::D_DATA_RGHT))) begin
      iv_next = '{data: instr_in.imm, oe: 1'b1, is_addr: 1'b0, right: instr_in.sel[0]}; // RQ10
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      iv_reg <= '{data: bei_pkg::IV_IDLE, oe: 1'b0, is_addr: 1'b0, right: 1'b0};
    end else begin
      iv_reg <= iv_next;
    end
  end

  assign addr_out = ar_reg;
  assign pc_out   = pc_reg;
  assign iv_out   = iv_reg;
  assign overflow_out = wreg_reg[bei_pkg::R_OVERFLOW];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_branch_reg_taken: assert property ( // RQ1
    is_branch && !bus_src && src_val != 8'h00 |=> ar_reg[7:0] == $past(instr_in.imm)
      && pc_reg[7:0] == $past(instr_in.imm))
    else $error("register branch target wrong");
  a_branch_reg_fall: assert property ( // RQ2
    is_branch && !bus_src && src_val == 8'h00 |=> pc_reg == $past(pc_reg) + bei_pkg::PC_STEP)
    else $error("register branch fallthrough wrong");
  a_branch_fall_addr: assert property ( // RQ2
    is_branch && !bus_src && src_val == 8'h00 |=> ar_reg == pc_reg)
    else $error("register branch fallthrough address wrong");
  a_branch_reg_upper: assert property ( // RQ18
    is_branch && !bus_src && src_val != 8'h00 |=> ar_reg[12:8] == $past(ar_reg[12:8])
      && pc_reg[12:8] == $past(pc_reg[12:8]))
    else $error("register branch upper bits changed");
  a_exec_reg_sum: assert property ( // RQ3
    is_exec && !bus_src |=> ar_reg[7:0] == $past(sum8) && ar_reg[12:8] == $past(ar_reg[12:8]))
    else $error("register indirect address wrong");
  a_exec_pc_hold: assert property ( // RQ4
    is_exec |=> pc_reg == $past(pc_reg))
    else $error("indirect execute moved counter");
  a_exec_then_step: assert property ( // RQ5
    is_exec ##1 !(is_branch || is_exec || is_jump) |=> pc_reg == $past(pc_reg) + bei_pkg::PC_STEP)
    else $error("counter did not step after indirect");
  a_exec_then_jump: assert property ( // RQ6
    is_exec ##1 is_jump |=> pc_reg == $past({instr_in.sel, instr_in.imm}))
    else $error("indirect jump did not load counter");
  a_jump_both_load: assert property ( // RQ17
    is_jump |=> ar_reg == $past({instr_in.sel, instr_in.imm}) && pc_reg == ar_reg)
    else $error("jump target wrong");
  a_overflow_kept: assert property ( // RQ7
    is_exec ##1 1'b1 |-> $stable(overflow_out))
    else $error("overflow changed by indirect");
  a_load_reg_write: assert property ( // RQ8
    wr_en |=> wreg_reg[$past(instr_in.sel[3:0])] == $past(instr_in.imm))
    else $error("immediate register load wrong");
  a_load_addr_bus: assert property ( // RQ9
    is_load && instr_in.sel == bei_pkg::D_ADDR_RGHT |=> iv_out.oe && iv_out.is_addr
      && iv_out.right && iv_out.data == $past(instr_in.imm) && wreg_reg[15] == iv_out.data)
    else $error("address immediate wrong");
  a_load_data_bus: assert property ( // RQ10
    is_load && instr_in.sel == bei_pkg::D_DATA_LEFT |=> iv_out.oe && !iv_out.is_addr
      && !iv_out.right && iv_out.data == $past(instr_in.imm) && $stable(wreg_reg[10]))
    else $error("data immediate wrong");
  a_load_data_right: assert property ( // RQ10
    is_load && instr_in.sel == bei_pkg::D_DATA_RGHT |=> iv_out.oe && !iv_out.is_addr
      && iv_out.right && iv_out.data == $past(instr_in.imm))
    else $error("right data immediate wrong");
  a_branch_bus_taken: assert property ( // RQ12
    is_branch && bus_src && field != 8'h00 |=> pc_reg[4:0] == $past(instr_in.imm[4:0])
      && pc_reg[12:5] == $past(pc_reg[12:5]) && ar_reg[4:0] == pc_reg[4:0])
    else $error("bus branch target wrong");
  a_branch_bus_fall: assert property ( // RQ13
    is_branch && bus_src && field == 8'h00 |=> pc_reg == $past(pc_reg) + bei_pkg::PC_STEP)
    else $error("bus branch fallthrough wrong");
  a_exec_bus_sum: assert property ( // RQ14
    is_exec && bus_src |=> ar_reg[4:0] == $past(sum5) && ar_reg[12:5] == $past(ar_reg[12:5]))
    else $error("bus indirect address wrong");
  a_exec_bus_wrap: assert property ( // RQ15
    is_exec && bus_src |=> ar_reg[4:0] == 5'($past(field[4:0]) + $past(instr_in.imm[4:0])))
    else $error("bus indirect carry not dropped");
  a_field_full_len: assert property ( // RQ16
    bus_src && instr_in.imm[7:5] == 3'h0 |-> field == ((bus_byte >> instr_in.sel[2:0])
      | 8'(bus_byte << (4'h8 - {1'b0, instr_in.sel[2:0]}))))
    else $error("zero length field not eight bits");
endmodule : bei_unit

// ===== bei_port_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// io ports on the left and right banks
// ------------------------------------------------------------
module bei_port_model (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire bei_pkg::bei_iv_s iv_in,
  output logic [7:0]            left_out,
  output logic [7:0]            right_out
);
  // each bank keeps the last data byte sent to it and presents it back
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      left_out  <= 8'h00;
      right_out <= 8'h00;
    end else if (iv_in.oe && !iv_in.is_addr) begin
      if (iv_in.right) begin
        right_out <= iv_in.data;
      end else begin
        left_out <= iv_in.data;
      end
    end
  end
endmodule : bei_port_model

// ===== tb_top.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// program rows, reset test, verdict
// ------------------------------------------------------------
module tb_top;
  typedef struct packed {
    logic [15:0] instr;
    logic [12:0] addr;
    logic [12:0] pc;
    logic [10:0] iv;
  } bei_row_s;
  logic                clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  bei_pkg::bei_instr_s instr_in = '0;
  logic [7:0]          iv_left, iv_right, overflow_out, overflow_first;
  logic [12:0]         addr_out, pc_out;
  bei_pkg::bei_iv_s    iv_out;
  bei_row_s            rows [23];
  int                  errors = 0;
  int                  samples_checked = 0;

  always #25 clk_in = ~clk_in;

  bei_unit bei_unit_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in),
    .iv_left_in(iv_left), .iv_right_in(iv_right), .addr_out(addr_out), .pc_out(pc_out),
    .iv_out(iv_out), .overflow_out(overflow_out));
  bei_port_model bei_port_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .iv_in(iv_out),
    .left_out(iv_left), .right_out(iv_right));

  task automatic chk(input logic [12:0] a, input logic [12:0] p, input logic [10:0] v);
    samples_checked++;
    if (addr_out !== a || pc_out !== p || iv_out !== v) begin
      errors++;
      $display("wrong value at %0t: addr %h pc %h iv %h", $time, addr_out, pc_out, iv_out);
    end
  endtask : chk

  task automatic results;
    $display("checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    #(50 * 2000);
    errors++;
    results();
  end

  initial begin
    rows = '{'{16'hc105, 13'h0001, 13'h0001, 11'h000}, '{16'hc200, 13'h0002, 13'h0002, 11'h000},
      '{16'ha280, 13'h0003, 13'h0003, 11'h000}, '{16'ha140, 13'h0040, 13'h0040, 11'h000},
      '{16'hc3fe, 13'h0041, 13'h0041, 11'h000}, '{16'h8305, 13'h0003, 13'h0041, 11'h000},
      '{16'h0000, 13'h0042, 13'h0042, 11'h000}, '{16'h8110, 13'h0015, 13'h0042, 11'h000},
      '{16'hfabc, 13'h1abc, 13'h1abc, 11'h000}, '{16'ha122, 13'h1a22, 13'h1a22, 11'h000},
      '{16'hcaa5, 13'h1a23, 13'h1a23, 11'h52c}, '{16'hcb3c, 13'h1a24, 13'h1a24, 11'h1e5},
      '{16'hc781, 13'h1a25, 13'h1a25, 11'h40e}, '{16'hcf42, 13'h1a26, 13'h1a26, 11'h217},
      '{16'hb26f, 13'h1a2f, 13'h1a2f, 11'h000}, '{16'hb85f, 13'h1a30, 13'h1a30, 11'h000},
      '{16'h901f, 13'h1a24, 13'h1a30, 11'h000}, '{16'ha100, 13'h1a00, 13'h1a00, 11'h000},
      '{16'hc877, 13'h1a01, 13'h1a01, 11'h000}, '{16'h8700, 13'h1a81, 13'h1a01, 11'h000},
      '{16'h0000, 13'h1a02, 13'h1a02, 11'h000}, '{16'h8f01, 13'h1a43, 13'h1a02, 11'h000},
      '{16'h0000, 13'h1a03, 13'h1a03, 11'h000}};
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    instr_in <= rows[0].instr;
    overflow_first = overflow_out;
    for (int i = 1; i <= 23; i++) begin
      @(posedge clk_in);
      instr_in <= (i < 23) ? rows[i].instr : 16'h0000;
      @(negedge clk_in);
      chk(rows[i-1].addr, rows[i-1].pc, rows[i-1].iv);
    end
    samples_checked++;
    if (overflow_out !== overflow_first || overflow_out === 8'h77) begin
      errors++;
      $display("wrong value at %0t: overflow register changed", $time);
    end
    $display("program rows done");
    @(posedge clk_in);
    instr_in <= 16'h8100;
    @(posedge clk_in);
    instr_in <= 16'he123;
    @(posedge clk_in);
    instr_in <= 16'h0000;
    @(negedge clk_in);
    chk(13'h0123, 13'h0123, 11'h000);
    $display("indirect jump test done");
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    #2;
    chk(13'h0000, 13'h0000, 11'h000);
    $display("reset test done");
    results();
  end
endmodule : tb_top
